// ### src/tcau_cmp_if.sv
// operand and result wires between the compare core and its helpers
`timescale 1ns/1ps
interface tcau_cmp_if;
  logic [15:0] timer;
  logic [15:0] period;
  logic [tcau_pkg::NCH-1:0][15:0] mv;
  logic [tcau_pkg::NCH-1:0][15:0] act;
  logic [tcau_pkg::NCH-1:0] pins;
  logic [tcau_pkg::NCH-1:0] full_hit;
  logic [tcau_pkg::NCH-1:0] fine_hit;
  logic period_hit;
  logic [tcau_pkg::NCH-1:0] pins_nxt;
  logic [1:0] irq_req;
  modport core (output timer, period, mv, act, pins,
    input full_hit, fine_hit, period_hit, pins_nxt, irq_req);
  modport cmp (input timer, period, mv, output full_hit, fine_hit, period_hit);
  modport decode (input act, pins, full_hit, output pins_nxt, irq_req);
endinterface

// ### src/tcau_match_unit.sv
// comparators: full-width and fine compare per channel, plus period end
`timescale 1ns/1ps
module tcau_match_unit (
  // compare operands and results
  tcau_cmp_if.cmp cif
);
  localparam int FB = tcau_pkg::FINE_BITS;
  genvar k;
  // one comparator pair per channel, all running every cycle
  generate
    for (k = 0; k < tcau_pkg::NCH; k = k + 1) begin : g_ch
      assign cif.full_hit[k] = (cif.mv[k] == cif.timer);
      assign cif.fine_hit[k] = (cif.mv[k][15 -: FB] == cif.timer[FB-1:0]);
    end
  endgenerate
  // only the low 14 bits compared, so the upper bits of period and timer are ignored
  assign cif.period_hit = (cif.period[FB-1:0] == cif.timer[FB-1:0]);
endmodule

// ### src/tcau_pin_action.sv
// normal-mode action decode: pin fields and interrupt requests per match
`timescale 1ns/1ps
module tcau_pin_action (
  // action words, pin levels and match results
  tcau_cmp_if.decode cif
);
  // one pin field applied to one pin level
  function automatic logic apply(input logic [1:0] f, input logic cur);
    logic v;
    v = cur;
    unique case (f)
      tcau_pkg::PA_KEEP: v = cur;
      tcau_pkg::PA_LOW: v = 1'b0;
      tcau_pkg::PA_HIGH: v = 1'b1;
      tcau_pkg::PA_FLIP: v = ~cur;
    endcase
    return v;
  endfunction

  logic [tcau_pkg::NCH-1:0] pins;
  logic [1:0] irq;
  // channels applied in order, so a later channel wins a conflict
  always_comb begin
    pins = cif.pins;
    irq = 2'b00;
    for (int ch = 0; ch < tcau_pkg::NCH; ch++) begin
      if (cif.full_hit[ch]) begin
        for (int p = 0; p < tcau_pkg::NCH; p++) begin
          pins[p] = apply(cif.act[ch][tcau_pkg::ACT_PIN_TOP - 2*p -: 2], pins[p]);
        end
        irq = irq | cif.act[ch][tcau_pkg::ACT_IRQ_B:tcau_pkg::ACT_IRQ_A];
      end
    end
    cif.pins_nxt = pins;
    cif.irq_req = irq;
  end
endmodule

// ### src/tcau_pkg.sv
// package: register map, field layout, reset values and state of the compare unit
package tcau_pkg;
  localparam int NCH = 6;
  localparam int FINE_BITS = 14;
  // banked port map
  localparam logic [3:0] BANK_TIMER = 4'h2;
  localparam logic [3:0] BANK_MATCH = 4'h3;
  localparam logic [3:0] BANK_ACTION = 4'h4;
  localparam logic [2:0] PORT_CONTROL = 3'h4;
  localparam logic [2:0] PORT_LAST = 3'h5;
  // control bits held here; the timer block owns the rest of the word
  localparam int CTL_PWM = 8;
  localparam int CTL_SEL = 9;
  localparam int CTL_EN = 10;
  localparam int CTL_SHA = 11;
  localparam int CTL_SHB = 12;
  localparam logic [15:0] CTL_MASK = 16'h1f00;
  // action word layout; bits 1..0 reserved and read as zero outside pwm mode
  localparam int ACT_PIN_TOP = 15;
  localparam int ACT_IRQ_A = 2;
  localparam int ACT_IRQ_B = 3;
  localparam logic [15:0] ACT_MASK = 16'hfffc;
  localparam int SHA_PIN = 4;
  localparam int SHB_PIN = 5;
  // values after reset and fixed patterns
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] MATCH_RESET = 16'h0000;
  localparam logic [15:0] ACT_RESET = 16'h0000;
  localparam logic [5:0] PIN_RESET = 6'h00;
  localparam logic [5:0] PIN_ALL = 6'h3f;
  localparam logic [1:0] DELAY_NONE = 2'h0;
  localparam logic [1:0] DELAY_LAST = 2'h1;
  typedef enum logic [1:0] {
    PA_KEEP = 2'b00,
    PA_LOW = 2'b01,
    PA_HIGH = 2'b10,
    PA_FLIP = 2'b11
  } tcau_pin_act_t;
  typedef struct packed {
    logic [15:0] ctl;
    logic [NCH-1:0][15:0] mv;
    logic [NCH-1:0][15:0] act;
    logic [NCH-1:0] pin;
    logic [NCH-1:0] busy;
    logic [NCH-1:0][1:0] cnt;
    logic [15:0] last;
    logic seen;
    logic irq_a;
    logic irq_b;
    logic rs1;
    logic rs2;
    logic [1:0] cap_s1;
    logic [1:0] cap_s2;
    logic [1:0] cap;
    logic [15:0] rd;
  } tcau_state_t;
endpackage

// ### src/tcau_top.sv
// compare core: banked registers, match sequencing, pwm periods and pin state
`timescale 1ns/1ps
module tcau_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SRST,
  // banked register port
  input wire logic [3:0] BANK_ADDR,
  input wire logic [2:0] PORT_ADDR,
  input wire logic WR_STROBE,
  input wire logic RD_STROBE,
  input wire logic [15:0] WR_DATA,
  output logic [15:0] RD_DATA,
  // timers and periods from the timer block, same clock
  input wire logic [15:0] COUNT_UNIT_ONE,
  input wire logic [15:0] COUNT_UNIT_TWO,
  input wire logic [15:0] PERIOD_ONE,
  input wire logic [15:0] PERIOD_TWO,
  output logic RESTART_ONE,
  output logic RESTART_TWO,
  // dedicated compare pins
  output logic [3:0] MATCH_OUTPUT_PIN,
  // shared compare or capture pins
  input wire logic SHARED_PIN_A_IN,
  output logic SHARED_PIN_A_OUT,
  output logic SHARED_PIN_A_OE,
  input wire logic SHARED_PIN_B_IN,
  output logic SHARED_PIN_B_OUT,
  output logic SHARED_PIN_B_OE,
  output logic [1:0] CAPTURE_IN,
  // flag set pulses toward the interrupt flag register
  output logic MATCH_IRQ_A,
  output logic MATCH_IRQ_B
);
  tcau_pkg::tcau_state_t st_r;
  tcau_pkg::tcau_state_t st_nxt;
  tcau_cmp_if cif ();

  logic en;
  logic pwm;
  logic sel_two;
  logic run;
  logic tick;
  logic hit_mv;
  logic hit_act;
  logic hit_ctl;
  logic [2:0] slot;
  logic [15:0] timer;
  logic [15:0] rd_val;

  // bank plus port decode, shared by the write and read paths
  function automatic logic is_reg(input logic [3:0] bank, input logic [3:0] want,
                                  input logic [2:0] port);
    return (bank == want) && (port <= tcau_pkg::PORT_LAST);
  endfunction

  // control state seen by the rest of the logic
  assign en = st_r.ctl[tcau_pkg::CTL_EN];
  assign pwm = st_r.ctl[tcau_pkg::CTL_PWM];
  assign sel_two = st_r.ctl[tcau_pkg::CTL_SEL];
  assign run = en && pwm;
  assign slot = PORT_ADDR;

  // register decode
  assign hit_mv = is_reg(BANK_ADDR, tcau_pkg::BANK_MATCH, PORT_ADDR);
  assign hit_act = is_reg(BANK_ADDR, tcau_pkg::BANK_ACTION, PORT_ADDR);
  assign hit_ctl = (BANK_ADDR == tcau_pkg::BANK_TIMER) && (PORT_ADDR == tcau_pkg::PORT_CONTROL);

  // selected timer and period
  assign timer = sel_two ? COUNT_UNIT_TWO : COUNT_UNIT_ONE;
  assign cif.timer = timer;
  assign cif.period = sel_two ? PERIOD_TWO : PERIOD_ONE;
  assign cif.mv = st_r.mv;
  assign cif.act = st_r.act;
  assign cif.pins = st_r.pin;

  // a prescaled timer holds its value for many clocks; act once per count
  assign tick = !st_r.seen || (timer != st_r.last);

  // comparators
  tcau_match_unit u_match (
    .cif(cif)
  );

  // normal-mode pin field and interrupt decode
  tcau_pin_action u_action (
    .cif(cif)
  );

  // read mux; unmapped ports read as zero
  always_comb begin
    rd_val = 16'h0000;
    if (hit_mv) begin
      rd_val = st_r.mv[slot];
    end else if (hit_act) begin
      rd_val = st_r.act[slot];
    end else if (hit_ctl) begin
      rd_val = st_r.ctl;
    end
  end

  // next state: writes first, then hardware updates which win over them
  always_comb begin
    st_nxt = st_r;
    st_nxt.irq_a = 1'b0;
    st_nxt.irq_b = 1'b0;
    st_nxt.rs1 = 1'b0;
    st_nxt.rs2 = 1'b0;
    // software writes
    if (WR_STROBE && hit_ctl) begin
      st_nxt.ctl = WR_DATA & tcau_pkg::CTL_MASK;
    end
    if (WR_STROBE && hit_act) begin
      // a pwm shadow must carry the quarter delay bits into its match register
      st_nxt.act[slot] = pwm ? WR_DATA : (WR_DATA & tcau_pkg::ACT_MASK);
    end
    if (WR_STROBE && hit_mv) begin
      st_nxt.mv[slot] = WR_DATA;
    end
    // remember the count just evaluated
    if (tick) begin
      st_nxt.last = timer;
      st_nxt.seen = 1'b1;
    end
    // quarter-phase countdown of delayed pwm clears
    for (int k = 0; k < tcau_pkg::NCH; k++) begin
      if (run && st_r.busy[k]) begin
        if (st_r.cnt[k] == tcau_pkg::DELAY_LAST) begin
          st_nxt.pin[k] = 1'b0;
          st_nxt.busy[k] = 1'b0;
        end else begin
          st_nxt.cnt[k] = st_r.cnt[k] - 2'h1;
        end
      end
    end
    // match evaluation, applied at the end of the matching cycle
    if (en && tick && !pwm) begin
      st_nxt.pin = cif.pins_nxt;
      st_nxt.irq_a = cif.irq_req[0];
      st_nxt.irq_b = cif.irq_req[1];
    end
    if (run && tick) begin
      for (int k = 0; k < tcau_pkg::NCH; k++) begin
        if (cif.fine_hit[k]) begin
          if (st_r.mv[k][1:0] == tcau_pkg::DELAY_NONE) begin
            st_nxt.pin[k] = 1'b0;
          end else begin
            st_nxt.busy[k] = 1'b1;
            st_nxt.cnt[k] = st_r.mv[k][1:0];
          end
        end
      end
      st_nxt.irq_a = cif.fine_hit[tcau_pkg::SHA_PIN];
      st_nxt.irq_b = cif.fine_hit[tcau_pkg::SHB_PIN];
      // period end restarts the frame and loads every shadow
      if (cif.period_hit) begin
        st_nxt.pin = tcau_pkg::PIN_ALL;
        st_nxt.busy = '0;
        st_nxt.mv = st_r.act;
        st_nxt.rs1 = !sel_two;
        st_nxt.rs2 = sel_two;
      end
    end
    // disabled: everything held quiet, writes to match registers lost
    if (!en) begin
      st_nxt.pin = tcau_pkg::PIN_RESET;
      st_nxt.mv = '0;
      st_nxt.busy = '0;
      st_nxt.seen = 1'b0;
      st_nxt.irq_a = 1'b0;
      st_nxt.irq_b = 1'b0;
    end
    // shared pin inputs pass two flops before use; gated off while driving
    st_nxt.cap_s1 = {SHARED_PIN_B_IN, SHARED_PIN_A_IN};
    st_nxt.cap_s2 = st_r.cap_s1;
    st_nxt.cap = st_r.cap_s2 & ~{st_r.ctl[tcau_pkg::CTL_SHB], st_r.ctl[tcau_pkg::CTL_SHA]};
    // read data is captured on the strobe and held until the next one
    if (RD_STROBE) begin
      st_nxt.rd = rd_val;
    end
  end

  // state register; reset values are constants only
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      st_r <= '0;
      st_r.ctl <= tcau_pkg::CTL_RESET;
      st_r.mv <= {tcau_pkg::NCH{tcau_pkg::MATCH_RESET}};
      st_r.act <= {tcau_pkg::NCH{tcau_pkg::ACT_RESET}};
      st_r.pin <= tcau_pkg::PIN_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign RD_DATA = st_r.rd;
  assign RESTART_ONE = st_r.rs1;
  assign RESTART_TWO = st_r.rs2;
  assign MATCH_OUTPUT_PIN = st_r.pin[3:0];
  assign SHARED_PIN_A_OUT = st_r.pin[tcau_pkg::SHA_PIN];
  assign SHARED_PIN_A_OE = st_r.ctl[tcau_pkg::CTL_SHA];
  assign SHARED_PIN_B_OUT = st_r.pin[tcau_pkg::SHB_PIN];
  assign SHARED_PIN_B_OE = st_r.ctl[tcau_pkg::CTL_SHB];
  assign CAPTURE_IN = st_r.cap;
  assign MATCH_IRQ_A = st_r.irq_a;
  assign MATCH_IRQ_B = st_r.irq_b;

  // disabled unit keeps pins, match registers and flag pulses at zero
  chk_disable_hold: assert property (
    @(posedge CLOCK) disable iff (SRST)
    !en |=> st_r.pin == tcau_pkg::PIN_RESET && st_r.mv == '0 && !MATCH_IRQ_A && !MATCH_IRQ_B)
    else $error("disabled unit moved a pin, match register or flag");

  // first clock after reset: dedicated pins low, shared pins floating
  chk_reset_pins: assert property (
    @(posedge CLOCK) disable iff (SRST)
    $past(SRST) |-> MATCH_OUTPUT_PIN == 4'h0 && !SHARED_PIN_A_OE && !SHARED_PIN_B_OE)
    else $error("pins not in reset state after reset");

  // a lone channel 0 match with field 10 drives pin 0 high next cycle
  chk_normal_set: assert property (
    @(posedge CLOCK) disable iff (SRST)
    en && !pwm && tick && cif.full_hit == 6'h01 && st_r.act[0][15:14] == 2'b10
    |=> st_r.pin[0])
    else $error("set action did not raise pin 0");

  // field 11 inverts, applied exactly one cycle after the match
  chk_normal_flip: assert property (
    @(posedge CLOCK) disable iff (SRST)
    en && !pwm && tick && cif.full_hit == 6'h01 && st_r.act[0][5:4] == 2'b11
    |=> st_r.pin[5] != $past(st_r.pin[5]))
    else $error("toggle action did not invert pin 5");

  // interrupt request bit turns a match into a one-cycle flag pulse
  chk_normal_irq: assert property (
    @(posedge CLOCK) disable iff (SRST)
    en && !pwm && tick && cif.full_hit[2] && st_r.act[2][tcau_pkg::ACT_IRQ_B]
    |=> MATCH_IRQ_B ##1 !MATCH_IRQ_B || tick)
    else $error("match with irq bit gave no flag pulse");

  // pwm: channel 5 fine match raises interrupt b whatever its action word
  chk_pwm_irq: assert property (
    @(posedge CLOCK) disable iff (SRST)
    run && tick && cif.fine_hit[tcau_pkg::SHB_PIN] |=> MATCH_IRQ_B)
    else $error("pwm channel 5 match gave no interrupt b");

  // pwm: zero quarter delay clears the pin at once
  chk_fine_now: assert property (
    @(posedge CLOCK) disable iff (SRST)
    run && tick && cif.fine_hit[1] && !cif.period_hit
    && st_r.mv[1][1:0] == tcau_pkg::DELAY_NONE |=> !st_r.pin[1])
    else $error("pwm match did not clear pin 1");

  // pwm: delay 2 clears two cycles later than an undelayed match
  sequence s_fine0_delay2;
    run && tick && cif.fine_hit[0] && !cif.period_hit && st_r.mv[0][1:0] == 2'h2;
  endsequence
  sequence s_quiet0;
    (run && !(tick && (cif.fine_hit[0] || cif.period_hit)))[*2];
  endsequence
  chk_quarter_delay: assert property (
    @(posedge CLOCK) disable iff (SRST)
    s_fine0_delay2 ##0 st_r.pin[0] ##1 s_quiet0 |-> st_r.pin[0] ##1 !st_r.pin[0])
    else $error("quarter delay of 2 cleared pin 0 at the wrong cycle");

  // pwm period end: all pins high, shadows loaded, timer restarted
  chk_period_end: assert property (
    @(posedge CLOCK) disable iff (SRST)
    run && tick && cif.period_hit |=> st_r.pin == tcau_pkg::PIN_ALL
    && st_r.mv == $past(st_r.act) && (RESTART_ONE != RESTART_TWO))
    else $error("period end did not set pins, load shadows or restart");

  // a match register written and then read back returns the value
  sequence s_mv_write;
    en && !pwm && WR_STROBE && hit_mv;
  endsequence
  sequence s_same_read;
    en && RD_STROBE && !WR_STROBE && $stable(BANK_ADDR) && $stable(PORT_ADDR);
  endsequence
  chk_match_readback: assert property (
    @(posedge CLOCK) disable iff (SRST)
    s_mv_write ##1 s_same_read |=> RD_DATA == $past(WR_DATA, 2))
    else $error("match register read back differs from write");

  // action registers read back with the reserved bits as zero outside pwm
  chk_action_readback: assert property (
    @(posedge CLOCK) disable iff (SRST)
    WR_STROBE && hit_act ##1 (RD_STROBE && !WR_STROBE && $stable(BANK_ADDR)
    && $stable(PORT_ADDR)) |=> RD_DATA == ($past(WR_DATA, 2)
    & ($past(pwm, 2) ? 16'hffff : tcau_pkg::ACT_MASK)))
    else $error("action register read back differs from write");

  // timer two selected: a match against it drives the pin
  chk_timer_two: assert property (
    @(posedge CLOCK) disable iff (SRST)
    en && !pwm && sel_two && tick && COUNT_UNIT_TWO == st_r.mv[3]
    && cif.full_hit == 6'h08 && st_r.act[3][9:8] == 2'b01 |=> !st_r.pin[3])
    else $error("match on timer two did not clear pin 3");

  // pwm period end pulses the restart of the selected timer only
  chk_restart_pick: assert property (
    @(posedge CLOCK) disable iff (SRST)
    run && tick && cif.period_hit |=> RESTART_ONE == !$past(sel_two)
    && RESTART_TWO == $past(sel_two))
    else $error("period end restarted the wrong timer");

  // pwm: channel 4 fine match raises interrupt a whatever its action word
  chk_pwm_irq_a: assert property (
    @(posedge CLOCK) disable iff (SRST)
    run && tick && cif.fine_hit[tcau_pkg::SHA_PIN]
    |=> MATCH_IRQ_A)
    else $error("pwm channel 4 match gave no interrupt a");

  // a shared pin driven for two cycles never feeds its own level to capture
  chk_capture_gate: assert property (
    @(posedge CLOCK) disable iff (SRST)
    (SHARED_PIN_A_OE && $past(SHARED_PIN_A_OE) |-> !CAPTURE_IN[0])
    and (SHARED_PIN_B_OE && $past(SHARED_PIN_B_OE) |-> !CAPTURE_IN[1]))
    else $error("driven shared pin leaked into capture input");

  // pwm: only a period end may raise a pin; action fields are ignored
  chk_pwm_no_rise: assert property (
    @(posedge CLOCK) disable iff (SRST)
    run && !(tick && cif.period_hit)
    |=> (st_r.pin & ~$past(st_r.pin)) == tcau_pkg::PIN_RESET)
    else $error("pwm pin rose without a period end");

  // a timer that holds its count is not evaluated again
  chk_tick_once: assert property (
    @(posedge CLOCK) disable iff (SRST)
    en && !pwm && !tick
    |=> st_r.pin == $past(st_r.pin) && !MATCH_IRQ_A && !MATCH_IRQ_B)
    else $error("held timer count was evaluated twice");

  // ports past the last channel read as zero
  chk_unmapped_read: assert property (
    @(posedge CLOCK) disable iff (SRST)
    RD_STROBE && BANK_ADDR == tcau_pkg::BANK_MATCH && PORT_ADDR > tcau_pkg::PORT_LAST
    |=> RD_DATA == 16'h0000)
    else $error("unmapped port read was not zero");

  // a disabled unit never asks a timer to restart
  chk_quiet_restart: assert property (
    @(posedge CLOCK) disable iff (SRST)
    !en |=> !RESTART_ONE && !RESTART_TWO)
    else $error("disabled unit pulsed a timer restart");
endmodule

// ### verification/tcau_pin_load.sv
// external circuit on one shared pin: a capture source while the pin is an input
`timescale 1ns/1ps
module tcau_pin_load (
  // clock of the source
  input wire logic clock,
  // driver side of the unit
  input wire logic oe,
  input wire logic drv,
  // resolved wire level fed back to the unit
  output logic level
);
  logic src_r;
  // source toggles every cycle so a stale level never passes for a driven one
  initial src_r = 1'b0;
  always @(posedge clock) begin
    src_r <= ~src_r;
  end
  // unit owns the wire only while enabled; otherwise the source drives it
  assign level = oe ? drv : src_r;
endmodule

// ### verification/tcau_top_tb.sv
// self-checking bench for the compare and action unit
`timescale 1ns/1ps
module tcau_top_tb;
  logic clock, srst, wr, rd, probe, rd_pend, sel;
  logic [3:0] bank, mpin;
  logic [2:0] port;
  logic [15:0] wdat, rdat, t1, t2, p1, p2, act;
  logic rs1, rs2, a_in, a_out, a_oe, b_in, b_out, b_oe, irq_a, irq_b;
  logic [15:0] exp_q[$];
  string name_q[$];
  logic [15:0] mv[6];
  logic [31:0] rnd;
  logic [5:0] pins;
  logic [1:0] oe_x, cap;
  int bad_count, total_checks, cycles;

  tcau_top tcau_top_i (.CLOCK(clock), .SRST(srst), .BANK_ADDR(bank), .PORT_ADDR(port),
    .WR_STROBE(wr), .RD_STROBE(rd), .WR_DATA(wdat), .RD_DATA(rdat),
    .COUNT_UNIT_ONE(t1), .COUNT_UNIT_TWO(t2), .PERIOD_ONE(p1), .PERIOD_TWO(p2),
    .RESTART_ONE(rs1), .RESTART_TWO(rs2), .MATCH_OUTPUT_PIN(mpin),
    .SHARED_PIN_A_IN(a_in), .SHARED_PIN_A_OUT(a_out), .SHARED_PIN_A_OE(a_oe),
    .SHARED_PIN_B_IN(b_in), .SHARED_PIN_B_OUT(b_out), .SHARED_PIN_B_OE(b_oe),
    .CAPTURE_IN(cap), .MATCH_IRQ_A(irq_a), .MATCH_IRQ_B(irq_b));
  tcau_pin_load pin_a_i (.clock(clock), .oe(a_oe), .drv(a_out), .level(a_in));
  tcau_pin_load pin_b_i (.clock(clock), .oe(b_oe), .drv(b_out), .level(b_in));

  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // expected pin levels after one action word
  function automatic logic [5:0] apply(input logic [5:0] p, input logic [15:0] a);
    logic [1:0] f;
    for (int k = 0; k < 6; k++) begin
      f = a[15 - 2 * k -: 2]; // pin 0 sits in the top pair
      case (f)
        2'b01: p[k] = 1'b0;
        2'b10: p[k] = 1'b1;
        2'b11: p[k] = ~p[k];
        default: p[k] = p[k];
      endcase
    end
    return p;
  endfunction

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen);
    logic [15:0] e;
    string n;
    e = exp_q.pop_front();
    n = name_q.pop_front();
    total_checks++;
    if (seen !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, seen);
    end
  endtask

  task automatic tick;
    @(posedge clock);
    #1;
  endtask

  // strobes drop for one idle cycle so back-to-back calls never collide
  task automatic wr_reg(input logic [3:0] b, input logic [2:0] p, input logic [15:0] d);
    bank = b;
    port = p;
    wdat = d;
    wr = 1'b1;
    tick;
    wr = 1'b0;
    tick;
  endtask

  task automatic rd_reg(input logic [3:0] b, input logic [2:0] p, input logic [15:0] e,
                        input string n);
    exp_q.push_back(e);
    name_q.push_back(n);
    bank = b;
    port = p;
    rd = 1'b1;
    tick;
    rd = 1'b0;
    tick;
  endtask

  // note the expected snapshot; probe drops after the watcher's edge so peeks chain
  // capture inputs sit in the top nibble and must read zero in every snapshot
  task automatic peek(input logic [1:0] irq, input logic [1:0] rs, input string n);
    exp_q.push_back({4'h0, irq, rs, oe_x, pins});
    name_q.push_back(n);
    probe = 1'b1;
    @(negedge clock);
    #1;
    probe = 1'b0;
    tick;
  endtask

  // write then read the same register in the next cycle, back to back
  task automatic wr_rd(input logic [3:0] b, input logic [2:0] p, input logic [15:0] d,
                       input logic [15:0] e, input string n);
    bank = b;
    port = p;
    wdat = d;
    wr = 1'b1;
    tick;
    exp_q.push_back(e);
    name_q.push_back(n);
    wr = 1'b0;
    rd = 1'b1;
    tick;
    rd = 1'b0;
    tick;
  endtask

  // unselected timer parks on a value no match register holds
  task automatic step(input logic [15:0] v);
    t1 = sel ? 16'h0008 : v;
    t2 = sel ? v : 16'h0008;
    tick;
  endtask

  task automatic endtest(input string n);
    $display("test %s finished", n);
  endtask

  // watcher: read data the cycle after its strobe, pin snapshot on request
  always @(negedge clock) begin
    if (rd_pend) check(rdat);
    rd_pend = rd;
    if (probe) check({2'b00, cap, irq_b, irq_a, rs2, rs1, b_oe, a_oe, b_out, a_out, mpin});
  end

  // hang guard, well above the fewer than two hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      wrap_up;
    end
  end

  initial begin
    {wr, rd, probe, rd_pend, sel} = 5'h00;
    bank = 4'h0;
    port = 3'h0;
    wdat = 16'h0000;
    t1 = 16'h0008;
    t2 = 16'h0008;
    p1 = 16'h0100;
    p2 = 16'h0033;
    pins = 6'h00;
    oe_x = 2'b00;
    rnd = 32'h5304;
    srst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    srst = 1'b0;
    peek(2'b00, 2'b00, "pins after reset");
    rd_reg(4'h2, 3'h4, 16'h0000, "control after reset");
    wr_reg(4'h3, 3'h0, 16'h1234);
    rd_reg(4'h3, 3'h0, 16'h0000, "match while disabled");
    wr_reg(4'h4, 3'h5, 16'hffff);
    rd_reg(4'h4, 3'h5, 16'hfffc, "action reserved bits");
    rd_reg(4'h3, 3'h6, 16'h0000, "unmapped port");
    endtest("reset");
    oe_x = 2'b11;
    wr_reg(4'h2, 3'h4, 16'hfcff);
    rd_reg(4'h2, 3'h4, 16'h1c00, "control readback");
    peek(2'b00, 2'b00, "shared pins driven");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      mv[i] = {rnd[15:4], i[3:0]}; // distinct low nibbles keep matches apart
      wr_rd(4'h3, i[2:0], mv[i], mv[i], "match readback");
    end
    endtest("enable");
    // random actions on each channel, first on timer one, then on timer two
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      wr_reg(4'h2, 3'h4, s[0] ? 16'h1e00 : 16'h1c00);
      for (int i = 0; i < 6; i++) begin
        rnd = lfsr(rnd);
        act = rnd[15:0] & 16'hfffc;
        // a few fields pinned so set, toggle, flag and timer-two paths all occur
        if (i == 0) act[15:14] = 2'b10;
        if (i == 0) act[5:4] = 2'b11;
        if (i == 2) act[3] = 1'b1;
        if (i == 3) act[9:8] = 2'b01;
        wr_rd(4'h4, i[2:0], {act[15:2], rnd[1:0]}, act, "action readback");
        step(mv[i]);
        pins = apply(pins, act);
        peek(act[3:2], 2'b00, "pins on match");
        peek(2'b00, 2'b00, "pins held");
        step(16'h0008);
      end
    end
    endtest("normal");
    // shadows hold fine targets; quarter delays 2, 0, 1, 3 on channels 0 to 3
    // pwm goes on first so the shadows keep their delay bits
    sel = 1'b0;
    wr_reg(4'h2, 3'h4, 16'h1d00);
    for (int i = 0; i < 6; i++) begin
      mv[i] = 16'((i + 1) * 64 + (i == 0 ? 2 : i == 2 ? 1 : i == 3 ? 3 : 0));
      wr_reg(4'h3, i[2:0], 16'hffff);
      wr_reg(4'h4, i[2:0], mv[i]);
    end
    step(16'hc100);
    pins = 6'h3f;
    peek(2'b00, 2'b01, "period end");
    for (int i = 0; i < 6; i++) rd_reg(4'h3, i[2:0], mv[i], "shadow load");
    for (int i = 0; i < 6; i++) begin
      step({2'b11, mv[i][15:2]});
      if (mv[i][1:0] != 2'b00) begin
        peek(2'b00, 2'b00, "fine delay wait");
        repeat (mv[i][1:0] - 1) tick;
      end
      pins[i] = 1'b0;
      peek({i == 5, i == 4}, 2'b00, "fine match clear");
    end
    endtest("pwm");
    wr_reg(4'h2, 3'h4, 16'h1800);
    pins = 6'h00;
    peek(2'b00, 2'b00, "disabled pins");
    rd_reg(4'h3, 3'h2, 16'h0000, "disabled match");
    endtest("disable");
    wrap_up;
  end
endmodule
